/* sarc_pkg.sv */
/*
  package for the converter control block: field widths, encodings,
  reset values and timing counts.
  assumes a single 40 MHz system clock domain.
*/
package sarc_pkg;

  // field widths
  localparam int unsigned RES_W  = 10;
  localparam int unsigned CHAN_W = 6;
  localparam int unsigned PREF_W = 2;

  // conversion length in bit periods, and system clocks per bit period
  localparam int unsigned CONV_PERIODS = 12;
  localparam int unsigned BIT_CLKS     = 4;
  localparam int unsigned STEP_W       = 4;
  localparam int unsigned DIV_W        = 8;

  // channel codes (encoding of this block)
  localparam logic [5:0] CHAN_PORTA0 = 6'h00;
  localparam logic [5:0] CHAN_PORTB4 = 6'h0C;
  localparam logic [5:0] CHAN_PORTC0 = 6'h10;
  localparam logic [5:0] CHAN_TEMP   = 6'h3C;
  localparam logic [5:0] CHAN_DAC    = 6'h3D;
  localparam logic [5:0] CHAN_FVR    = 6'h3E;
  localparam logic [5:0] CHAN_GND    = 6'h3F;

  // positive reference encodings
  localparam logic [1:0] PREF_PIN    = 2'h0;
  localparam logic [1:0] PREF_SUPPLY = 2'h1;
  localparam logic [1:0] PREF_FVR2   = 2'h2;
  localparam logic [1:0] PREF_FVR4   = 2'h3;

  // reset values
  localparam logic [9:0] RESULT_RST = 10'h000;
  localparam logic [5:0] CHAN_RST   = 6'h00;

  // selections latched at conversion start
  typedef struct packed {
    logic [5:0] chan;
    logic [1:0] pref;
    logic       nref;
  } sarc_sel_t;

  // conversion state
  typedef enum logic [1:0] {
    SARC_IDLE = 2'b00,
    SARC_CONV = 2'b01,
    SARC_DONE = 2'b11
  } sarc_state_t;

endpackage

/* sarc_approx.sv */
/*
  successive approximation register: one bit decided per step, msb first.
  assumes the comparator input is valid when step_i pulses.
*/
`timescale 1ns/1ps
module sarc_approx #(
  parameter int unsigned WIDTH = 10
) (
  // clock and reset
  input  wire logic             clk_i,
  input  wire logic             reset_i,
  // control
  input  wire logic             start_i,
  input  wire logic             step_i,
  input  wire logic             comp_high_i,
  // trial code toward the dac, and ready flag
  output logic [WIDTH-1:0]      trial_o,
  output logic                  ready_o
);

  logic [WIDTH-1:0] mask_reg;
  logic [WIDTH-1:0] code_reg;

  // trial code with the bit under test set
  always_ff @(posedge clk_i) begin
    if (reset_i || start_i) begin
      code_reg <= '0;
      mask_reg <= {1'b1, {(WIDTH-1){1'b0}}};
    end else if (step_i && (mask_reg != '0)) begin
      if (!comp_high_i) begin
        code_reg <= code_reg | mask_reg; // input above trial: keep bit
      end
      mask_reg <= mask_reg >> 1;
    end
  end

  assign trial_o = code_reg | mask_reg;
  assign ready_o = (mask_reg == '0);

endmodule

/* sarc_top.sv */
/*
  converter control: channel and reference selection into one sample and
  hold, conversion sequencing, result pair and completion flag.
  assumes software-side bits arrive as synchronous levels and pulses, and
  that the analog comparator answers within one system clock.
*/
`timescale 1ns/1ps
module sarc_top #(
  parameter int unsigned BIT_CLKS = sarc_pkg::BIT_CLKS,
  parameter bit          LOW_VOLTAGE = 1'b0
) (
  // clock and reset
  input  wire logic                  clk_i,
  input  wire logic                  reset_i,
  // software control
  input  wire logic                  converter_enable_i,
  input  wire logic                  go_set_i,
  input  wire logic [5:0]            input_channel_select_i,
  input  wire logic [1:0]            positive_reference_select_i,
  input  wire logic                  negative_reference_select_i,
  input  wire logic                  result_justify_select_i,
  input  wire logic                  irq_flag_clear_i,
  input  wire logic                  irq_enable_i,
  input  wire logic                  sleeping_i,
  // analog side
  input  wire logic                  comp_high_i,
  // analog control outputs
  output logic [5:0]                 mux_channel_o,
  output logic [1:0]                 pos_ref_o,
  output logic                       neg_ref_o,
  output logic                       sample_hold_o,
  output logic [9:0]                 dac_trial_o,
  // status outputs
  output logic                       go_busy_o,
  output logic                       conversion_done_irq_flag_o,
  output logic                       wake_o,
  output logic [7:0]                 result_high_byte_o,
  output logic [7:0]                 result_low_byte_o
);

  sarc_pkg::sarc_state_t state_reg;
  sarc_pkg::sarc_sel_t   sel_reg;
  logic                  enable_d_reg;
  logic [7:0]            div_reg;
  logic [3:0]            period_reg;
  logic                  bit_tick;
  logic                  sar_start;
  logic                  sar_step;
  logic [9:0]            trial;
  logic [9:0]            code_reg;
  logic                  go_accept;
  logic                  finish;

  // go counts only when the block was already enabled before this cycle
  assign go_accept = go_set_i && converter_enable_i && enable_d_reg
                     && (state_reg == sarc_pkg::SARC_IDLE);
  assign bit_tick  = (div_reg == 8'(BIT_CLKS - 1));
  assign finish    = (state_reg == sarc_pkg::SARC_CONV) && bit_tick
                     && (period_reg == 4'(sarc_pkg::CONV_PERIODS - 1));
  assign sar_start = go_accept;
  // periods 0 and 1 sample and settle, 2..11 decide the ten bits
  assign sar_step  = (state_reg == sarc_pkg::SARC_CONV) && bit_tick && (period_reg >= 4'h2);

  // enable history for the same-write guard
  always_ff @(posedge clk_i) begin
    if (reset_i) enable_d_reg <= 1'b0;
    else         enable_d_reg <= converter_enable_i;
  end

  // conversion sequencing; disable aborts
  always_ff @(posedge clk_i) begin
    if (reset_i || !converter_enable_i) begin
      state_reg <= sarc_pkg::SARC_IDLE;
    end else begin
      unique case (state_reg)
        sarc_pkg::SARC_IDLE: if (go_accept) state_reg <= sarc_pkg::SARC_CONV;
        sarc_pkg::SARC_CONV: if (finish) state_reg <= sarc_pkg::SARC_DONE;
        sarc_pkg::SARC_DONE: state_reg <= sarc_pkg::SARC_IDLE;
        default:             state_reg <= sarc_pkg::SARC_IDLE;
      endcase
    end
  end

  // bit period divider and period counter
  always_ff @(posedge clk_i) begin
    if (reset_i || state_reg != sarc_pkg::SARC_CONV) begin
      div_reg    <= '0;
      period_reg <= '0;
    end else if (bit_tick) begin
      div_reg    <= '0;
      period_reg <= period_reg + 4'h1;
    end else begin
      div_reg <= div_reg + 8'h01;
    end
  end

  // selections latched at go; on low-voltage parts 4.096V falls back to 2.048V only in the latched copy used during conversion
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      sel_reg <= '{chan: sarc_pkg::CHAN_RST, pref: sarc_pkg::PREF_PIN, nref: 1'b0};
    end else if (go_accept) begin
      sel_reg.chan <= input_channel_select_i;
      sel_reg.pref <= (LOW_VOLTAGE && positive_reference_select_i == sarc_pkg::PREF_FVR4)
                      ? sarc_pkg::PREF_FVR2 : positive_reference_select_i;
      sel_reg.nref <= negative_reference_select_i;
    end
  end

  // analog control: mux and sample-and-hold, live when idle
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      mux_channel_o <= sarc_pkg::CHAN_RST;
      pos_ref_o     <= sarc_pkg::PREF_PIN;
      neg_ref_o     <= 1'b0;
      sample_hold_o <= 1'b0;
      dac_trial_o   <= '0;
    end else begin
      mux_channel_o <= (state_reg == sarc_pkg::SARC_CONV) ? sel_reg.chan
                       : input_channel_select_i;
      pos_ref_o     <= (state_reg == sarc_pkg::SARC_CONV) ? sel_reg.pref
                       : positive_reference_select_i;
      neg_ref_o     <= (state_reg == sarc_pkg::SARC_CONV) ? sel_reg.nref
                       : negative_reference_select_i;
      // track while idle and enabled, hold during decisions
      sample_hold_o <= converter_enable_i && !((state_reg == sarc_pkg::SARC_CONV)
                       && period_reg >= 4'h1);
      dac_trial_o   <= trial;
    end
  end

  sarc_approx #(
    .WIDTH (sarc_pkg::RES_W)
  ) u_approx (
    .clk_i       (clk_i),
    .reset_i     (reset_i),
    .start_i     (sar_start),
    .step_i      (sar_step),
    .comp_high_i (comp_high_i),
    .trial_o     (trial),
    .ready_o     ()
  );

  // result capture at finish; the lsb is still under test here, so its
  // decision comes straight from the comparator
  always_ff @(posedge clk_i) begin
    if (reset_i) code_reg <= sarc_pkg::RESULT_RST;
    else if (finish) code_reg <= {trial[9:1], !comp_high_i};
  end

  // justified result pair, follows the format bit at any time
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      result_high_byte_o <= '0;
      result_low_byte_o  <= '0;
    end else if (result_justify_select_i) begin
      result_high_byte_o <= {6'h00, code_reg[9:8]}; // right
      result_low_byte_o  <= code_reg[7:0];
    end else begin
      result_high_byte_o <= code_reg[9:2]; // left
      result_low_byte_o  <= {code_reg[1:0], 6'h00};
    end
  end

  // go bit, completion flag (set wins over clear) and wake
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      go_busy_o                  <= 1'b0;
      conversion_done_irq_flag_o <= 1'b0;
      wake_o                     <= 1'b0;
    end else begin
      go_busy_o <= go_accept || (go_busy_o && !finish && converter_enable_i);
      if (finish) conversion_done_irq_flag_o <= 1'b1;
      else if (irq_flag_clear_i) conversion_done_irq_flag_o <= 1'b0;
      wake_o <= sleeping_i && irq_enable_i
                && (finish || conversion_done_irq_flag_o);
    end
  end

endmodule

/* sarc_checker.sv */
/*
  concurrent checks on the converter control ports.
  assumes one clock, synchronous active-high reset, bound into sarc_top.
*/
`timescale 1ns/1ps
module sarc_checker #(
  parameter int unsigned BIT_CLKS = sarc_pkg::BIT_CLKS
) (
  // clock and reset
  input wire logic       clk_i,
  input wire logic       reset_i,
  // software control
  input wire logic       converter_enable_i,
  input wire logic       go_set_i,
  input wire logic [5:0] input_channel_select_i,
  input wire logic [1:0] positive_reference_select_i,
  input wire logic       negative_reference_select_i,
  input wire logic       irq_enable_i,
  input wire logic       sleeping_i,
  // watched outputs
  input wire logic [5:0] mux_channel_o,
  input wire logic [1:0] pos_ref_o,
  input wire logic       neg_ref_o,
  input wire logic       go_busy_o,
  input wire logic       conversion_done_irq_flag_o,
  input wire logic       wake_o
);
  localparam int CONV = sarc_pkg::CONV_PERIODS * BIT_CLKS;
  logic [7:0] cnt_reg;
  default clocking @(posedge clk_i); endclocking
  default disable iff (reset_i);
  // cycles spent busy
  always_ff @(posedge clk_i) begin
    cnt_reg <= go_busy_o ? cnt_reg + 8'h01 : 8'h00;
  end
  // go seen while idle, enable held over two cycles
  sequence s_take;
    go_set_i && converter_enable_i && $past(converter_enable_i) && !go_busy_o && !$past(go_busy_o);
  endsequence
  // conversion ends with module still enabled
  sequence s_finish;
    $fell(go_busy_o) && converter_enable_i;
  endsequence
  property p_take; s_take |=> go_busy_o; endproperty
  a_take: assert property (p_take) else $error("go not taken");
  property p_first;
    go_set_i && converter_enable_i && !$past(converter_enable_i) |=> !go_busy_o;
  endproperty
  a_first: assert property (p_first) else $error("go taken in enabling cycle");
  property p_off; !converter_enable_i |=> !go_busy_o; endproperty
  a_off: assert property (p_off) else $error("busy while disabled");
  property p_len; s_finish |-> int'(cnt_reg) == CONV; endproperty
  a_len: assert property (p_len) else $error("wrong conversion length");
  property p_done; s_finish |-> conversion_done_irq_flag_o; endproperty
  a_done: assert property (p_done) else $error("flag not set at finish");
  property p_abort;
    $fell(go_busy_o) && !converter_enable_i |-> !$rose(conversion_done_irq_flag_o);
  endproperty
  a_abort: assert property (p_abort) else $error("flag set on abort");
  property p_wake;
    sleeping_i && irq_enable_i && conversion_done_irq_flag_o |=> wake_o;
  endproperty
  a_wake: assert property (p_wake) else $error("no wake");
  property p_nowake; !sleeping_i || !irq_enable_i |=> !wake_o; endproperty
  a_nowake: assert property (p_nowake) else $error("stray wake");
  property p_live;
    !go_busy_o |=> mux_channel_o == $past(input_channel_select_i)
      && pos_ref_o == $past(positive_reference_select_i)
      && neg_ref_o == $past(negative_reference_select_i);
  endproperty
  a_live: assert property (p_live) else $error("selection not followed");
  property p_hold;
    go_busy_o && $past(go_busy_o) |-> $stable(mux_channel_o) && $stable(pos_ref_o)
      && $stable(neg_ref_o);
  endproperty
  a_hold: assert property (p_hold) else $error("selection moved in conversion");
endmodule
bind sarc_top sarc_checker #(.BIT_CLKS(BIT_CLKS)) u_chk (.*);

/* sarc_top_tb_top.sv */
/*
  self-checking bench for sarc_top.
  assumes the comparator answers trial above held level, driven at negedge.
*/
`timescale 1ns/1ps
module sarc_top_tb_top;
  logic        clk_i = 1'b0, reset_i = 1'b1, en = 1'b0, go = 1'b0, nref = 1'b0;
  logic        jus = 1'b0, clr = 1'b0, ien = 1'b0, slp = 1'b0, comp = 1'b0;
  logic [5:0]  chs = 6'h00, mux;
  logic [1:0]  pref = 2'h0, pr;
  logic        nr, busy, flag, wake, sh;
  logic [9:0]  lvl = 10'h000, trial;
  logic [7:0]  hi, lo;
  logic [15:0] exp_q[$];
  logic [31:0] seed = 32'h0382;
  logic [5:0]  codes[7] = '{sarc_pkg::CHAN_PORTA0, sarc_pkg::CHAN_PORTB4,
                            sarc_pkg::CHAN_PORTC0, sarc_pkg::CHAN_TEMP,
                            sarc_pkg::CHAN_DAC, sarc_pkg::CHAN_FVR, sarc_pkg::CHAN_GND};
  int          n_mismatch = 0, num_checks = 0, cyc = 0;
  sarc_top #(.BIT_CLKS(2)) dut (.clk_i(clk_i), .reset_i(reset_i),
    .converter_enable_i(en), .go_set_i(go), .input_channel_select_i(chs),
    .positive_reference_select_i(pref), .negative_reference_select_i(nref),
    .result_justify_select_i(jus), .irq_flag_clear_i(clr), .irq_enable_i(ien),
    .sleeping_i(slp), .comp_high_i(comp), .mux_channel_o(mux), .pos_ref_o(pr),
    .neg_ref_o(nr), .sample_hold_o(sh), .dac_trial_o(trial), .go_busy_o(busy),
    .conversion_done_irq_flag_o(flag), .wake_o(wake), .result_high_byte_o(hi),
    .result_low_byte_o(lo));
  // clock, comparator model and cycle ceiling
  always #12.5 clk_i = ~clk_i;
  always @(negedge clk_i) comp <= (trial > lvl);
  always @(posedge clk_i) begin
    cyc++;
    if (cyc > 5000) begin
      n_mismatch++;
      report_and_stop();
    end
  end
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  task automatic chk(input logic [15:0] got, input logic [15:0] want);
    num_checks++;
    if (got !== want) begin
      n_mismatch++;
      $display("mismatch t=%0t got=%h want=%h", $time, got, want);
    end
  endtask
  task automatic report_and_stop();
    if (n_mismatch == 0 && num_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // one conversion: note expectation, start, disturb selections, wait
  task automatic conv(input logic [9:0] v, input logic j);
    logic [5:0] c;
    logic [1:0] p;
    logic       r;
    int n;
    c = chs;
    p = pref;
    r = nref;
    lvl = v;
    jus = j;
    exp_q.push_back(j ? {6'h00, v} : {v, 6'h00});
    go = 1'b1;
    @(negedge clk_i);
    go = 1'b0;
    chs = ~chs;
    pref = ~pref;
    nref = ~nref;
    @(negedge clk_i);
    chk({7'h00, mux, pr, nr}, {7'h00, c, p, r});
    repeat (3) @(negedge clk_i);
    chk({15'h0, sh}, 16'h0000);
    n = 0;
    while (flag !== 1'b1 && n < 200) begin
      @(negedge clk_i);
      n++;
    end
    if (n >= 200) begin
      n_mismatch++;
      report_and_stop();
    end
    @(negedge clk_i);
    chk({15'h0, wake}, {15'h0, slp & ien});
    chk({15'h0, sh}, 16'h0001);
    @(negedge clk_i);
    clr = 1'b1;
    @(negedge clk_i);
    clr = 1'b0;
    @(negedge clk_i);
  endtask
  // result watcher: oldest note against the result pair
  initial forever begin
    @(posedge flag);
    @(negedge clk_i);
    @(negedge clk_i);
    chk({hi, lo}, exp_q.pop_front());
  end
  initial begin
    repeat (16) @(posedge clk_i);
    @(negedge clk_i);
    reset_i = 1'b0;
    chk({hi, lo}, 16'h0000);
    chk({13'h0, busy, flag, wake}, 16'h0000);
    go = 1'b1;
    @(negedge clk_i);
    en = 1'b1;
    @(negedge clk_i);
    go = 1'b0;
    @(negedge clk_i);
    chk({15'h0, busy}, 16'h0000);
    // analog pins taken as already set to input and analog: no such port here
    for (int i = 0; i < 12; i++) begin
      seed = xs(seed);
      chs = sarc_pkg::CHAN_GND;
      @(negedge clk_i);
      chs = codes[i % 7];
      pref = seed[1:0];
      nref = seed[2];
      slp = seed[4];
      ien = seed[5];
      repeat (4) @(negedge clk_i);
      conv(i == 0 ? 10'h000 : i == 1 ? 10'h3FF : seed[17:8], seed[3]);
    end
    go = 1'b1;
    @(negedge clk_i);
    go = 1'b0;
    repeat (5) @(negedge clk_i);
    en = 1'b0;
    repeat (4) @(negedge clk_i);
    chk({14'h0, busy, flag}, 16'h0000);
    chk(16'(exp_q.size()), 16'h0000);
    report_and_stop();
  end
endmodule
